// *** rtl/bat_card.sv ***
// Card end: command intake, status policy and chained response output.
// Notes on behaviour
// - Terminal puts command bytes unaltered in I-blocks.
// - Data only with 61,62,63,9X or 9000 status.
// - Terminal passes response field unaltered upward.
// - Long response chained; terminal concatenates in order.
// - Terminal may chain command data over blocks.
// - Case 4 response single or chained blocks.
// - All four data cases are handled.
// - Exactly one response per command unit.
// - 91XX replaces 9000 when proactive command pending.
// - FETCH returns pending command with 9000.
// - Terminal reports outcome with TERMINAL RESPONSE.
// - Busy toolkit answers ENVELOPE with 9300.
// - ENVELOPE is case 4, code C2, Le 00.
// - ENVELOPE 9000 data is positive acknowledgement.
// - ENVELOPE 62XX/63XX data is negative acknowledgement.
`timescale 1ns/100ps
`include "bat_cfg.svh"

////////////////////////////////////////////////////////////////////////
// Card transport end.
module bat_card #(
   parameter int BLK_MAX = `BAT_BLK_MAX,
   parameter int FIFO_DEPTH = `BAT_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst,
   bat_link_if.card link,
   output bat_pkg::bat_byte_t cmd_data,
   output logic cmd_valid,
   output logic cmd_end,
   input wire logic cmd_ready,
   output bat_pkg::bat_byte_t cmd_ins,
   input wire logic [7:0] sw1,
   input wire logic [7:0] sw2,
   input wire logic [7:0] rsp_len,
   input wire logic sw_valid,
   output logic sw_ready,
   input wire logic [7:0] rsp_data,
   input wire logic rsp_valid,
   output logic rsp_ready,
   input wire logic [7:0] pending_len,
   input wire logic toolkit_busy
);
   import bat_pkg::*;
   bat_card_state_e state_reg;
   logic [7:0] idx_reg;
   logic busy_reg;
   logic keep_reg;
   logic [7:0] left_reg;
   logic [7:0] blk_reg;
   logic [7:0] sw1_reg;
   logic [7:0] sw2_reg;
   logic [7:0] sw1_next;
   logic [7:0] sw2_next;
   logic allow;
   logic take;
   logic cmd_done;
   logic [7:0] f_data;
   logic f_valid;
   logic f_ready;
   logic send;
   logic blk_full;

   initial begin
      if (BLK_MAX < 3 || BLK_MAX > 254) begin
         $error("bat_card: BLK_MAX must lie in 3..254");
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Command intake through a one byte register stage.
   assign link.t2c_ready = (state_reg == BAT_C_CMD) &&
      (!cmd_valid || cmd_ready);
   assign take = link.t2c_valid && link.t2c_ready;
   assign cmd_done = take && link.t2c_last && !link.t2c_chain;

   // Every command byte reaches the card application unaltered.
   always_ff @(posedge clk) begin
      if (rst) begin
         cmd_data <= 8'h00;
         cmd_valid <= 1'b0;
         cmd_end <= 1'b0;
      end else if (take) begin
         cmd_data <= link.t2c_data;
         cmd_valid <= 1'b1;
         cmd_end <= !link.t2c_chain && link.t2c_last;
      end else if (cmd_ready) begin
         cmd_valid <= 1'b0;
         cmd_end <= 1'b0;
      end
   end

   // Byte index within the unit finds the instruction byte.
   always_ff @(posedge clk) begin
      if (rst) begin
         idx_reg <= 8'h00;
         cmd_ins <= 8'h00;
         busy_reg <= 1'b0;
      end else if (take) begin
         idx_reg <= cmd_done ? 8'h00 : idx_reg + 8'h01;
         if (idx_reg == `BAT_INS_POS) begin
            cmd_ins <= link.t2c_data;
            // A busy toolkit is latched for this ENVELOPE only.
            busy_reg <= toolkit_busy &&
               (link.t2c_data == `BAT_INS_ENVELOPE);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Status policy: final status words and whether data may go out.
   always_comb begin
      sw1_next = sw1;
      sw2_next = sw2;
      if (busy_reg) begin
         sw1_next = `BAT_SW1_BUSY;
         sw2_next = `BAT_SW2_BUSY;
      end else if (sw1 == `BAT_SW1_OK && sw2 == `BAT_SW2_OK &&
            pending_len != 8'h00 && cmd_ins != `BAT_INS_FETCH) begin
         // FETCH itself keeps a plain 9000; it is never turned into 91XX.
         sw1_next = `BAT_SW1_PENDING;
         sw2_next = pending_len;
      end
   end

   // Only the listed status classes may carry response data.
   assign allow = !busy_reg && (sw1_next == `BAT_SW1_NORMAL ||
      sw1_next == `BAT_SW1_WARN_A || sw1_next == `BAT_SW1_WARN_B ||
      sw1_next[7:4] == `BAT_SW1_APP_NIB);

   assign sw_ready = (state_reg == BAT_C_STATUS);

   ////////////////////////////////////////////////////////////////////
   // Response path: data is buffered, then drained or discarded.
   bat_fifo #(
      .WIDTH(`BAT_BYTE_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_data(rsp_data),
      .in_valid(rsp_valid),
      .in_ready(rsp_ready),
      .out_data(f_data),
      .out_valid(f_valid),
      .out_ready(f_ready)
   );

   // Discarded data is popped at full rate so the source never hangs.
   assign f_ready = (state_reg == BAT_C_DATA) &&
      (keep_reg ? link.c2t_ready : 1'b1);
   assign blk_full = (blk_reg == 8'(BLK_MAX - 1));
   assign send = link.c2t_valid && link.c2t_ready;

   // Outgoing bytes: data first, status words close the last block.
   always_comb begin
      link.c2t_valid = 1'b0;
      link.c2t_data = 8'h00;
      link.c2t_last = 1'b0;
      link.c2t_chain = 1'b0;
      case (state_reg)
         BAT_C_DATA: begin
            link.c2t_valid = f_valid && keep_reg;
            link.c2t_data = f_data;
            link.c2t_last = blk_full;
            link.c2t_chain = blk_full;
         end
         BAT_C_SW1: begin
            link.c2t_valid = 1'b1;
            link.c2t_data = sw1_reg;
            link.c2t_last = blk_full;
            link.c2t_chain = blk_full;
         end
         BAT_C_SW2: begin
            link.c2t_valid = 1'b1;
            link.c2t_data = sw2_reg;
            link.c2t_last = 1'b1;
         end
         default: begin
         end
      endcase
   end

   // Bytes in the current outgoing block; a full block is chained.
   always_ff @(posedge clk) begin
      if (rst || state_reg == BAT_C_STATUS) begin
         blk_reg <= 8'h00;
      end else if (send) begin
         blk_reg <= blk_full ? 8'h00 : blk_reg + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Exchange sequence: one command unit, then one response unit.
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= BAT_C_CMD;
         keep_reg <= 1'b0;
         left_reg <= 8'h00;
         sw1_reg <= 8'h00;
         sw2_reg <= 8'h00;
      end else begin
         case (state_reg)
            BAT_C_CMD: begin
               if (cmd_done) begin
                  state_reg <= BAT_C_STATUS;
               end
            end
            BAT_C_STATUS: begin
               if (sw_valid) begin
                  sw1_reg <= sw1_next;
                  sw2_reg <= sw2_next;
                  keep_reg <= allow;
                  left_reg <= rsp_len;
                  // Cases 1 and 3 carry no data and go to status.
                  state_reg <= (rsp_len == 8'h00) ? BAT_C_SW1 :
                     BAT_C_DATA;
               end
            end
            BAT_C_DATA: begin
               if (f_valid && f_ready) begin
                  left_reg <= left_reg - 8'h01;
                  if (left_reg == 8'h01) begin
                     state_reg <= BAT_C_SW1;
                  end
               end
            end
            BAT_C_SW1: begin
               if (send) begin
                  state_reg <= BAT_C_SW2;
               end
            end
            BAT_C_SW2: begin
               if (send) begin
                  state_reg <= BAT_C_CMD;
               end
            end
            default: begin
               state_reg <= BAT_C_CMD;
            end
         endcase
      end
   end
endmodule

// *** rtl/bat_cfg.svh ***
// Constants for the block APDU transport, shared by both ends.
`ifndef BAT_CFG_SVH
`define BAT_CFG_SVH
`define BAT_INS_POS 8'h01
`define BAT_INS_FETCH 8'h12
`define BAT_INS_TERM_RSP 8'h14
`define BAT_INS_ENVELOPE 8'hC2
`define BAT_LE_ANY 8'h00
`define BAT_SW1_OK 8'h90
`define BAT_SW2_OK 8'h00
`define BAT_SW1_NORMAL 8'h61
`define BAT_SW1_WARN_A 8'h62
`define BAT_SW1_WARN_B 8'h63
`define BAT_SW1_APP_NIB 4'h9
`define BAT_SW1_PENDING 8'h91
`define BAT_SW1_BUSY 8'h93
`define BAT_SW2_BUSY 8'h00
`define BAT_BLK_MAX 32
`define BAT_FIFO_DEPTH 8
`define BAT_BYTE_W 8
`endif

// *** rtl/bat_pkg.sv ***
// Types shared by the card end and the terminal end.
package bat_pkg;
   typedef logic [7:0] bat_byte_t;
   typedef enum logic [2:0] {
      BAT_C_CMD, BAT_C_STATUS, BAT_C_DATA, BAT_C_SW1, BAT_C_SW2
   } bat_card_state_e;
   typedef enum logic [1:0] {
      BAT_T_SEND, BAT_T_WAIT
   } bat_term_state_e;
endpackage

// *** rtl/bat_link_if.sv ***
// Byte link carrying I-block information fields in both directions.
`timescale 1ns/100ps
interface bat_link_if;
   // Terminal to card: byte, end of block, block is chained.
   logic [7:0] t2c_data;
   logic t2c_valid;
   logic t2c_last;
   logic t2c_chain;
   logic t2c_ready;
   // Card to terminal, same meaning.
   logic [7:0] c2t_data;
   logic c2t_valid;
   logic c2t_last;
   logic c2t_chain;
   logic c2t_ready;
   modport card (
      input t2c_data, t2c_valid, t2c_last, t2c_chain, c2t_ready,
      output t2c_ready, c2t_data, c2t_valid, c2t_last, c2t_chain
   );
   modport term (
      input c2t_data, c2t_valid, c2t_last, c2t_chain, t2c_ready,
      output c2t_ready, t2c_data, t2c_valid, t2c_last, t2c_chain
   );
endinterface

// *** rtl/bat_term.sv ***
// Terminal end, and the byte FIFO that the card end buffers with.
`timescale 1ns/100ps
`include "bat_cfg.svh"

////////////////////////////////////////////////////////////////////////
// Response byte FIFO with valid and ready on both sides.
module bat_fifo #(
   parameter int WIDTH = `BAT_BYTE_W,
   parameter int DEPTH = `BAT_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] cnt_reg;
   logic push;
   logic pop;

   // Depth must be a power of two so the pointers wrap by themselves.
   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
         $error("bat_fifo: DEPTH must be a power of two >= 2");
      end
   end

   // Full and empty follow the occupancy count, compared at full width.
   assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem_reg[rd_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Storage has no reset; only the pointers and the occupancy count need a defined value.
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data;
      end
   end

   // Pointers and occupancy.
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= rd_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////
// Terminal transport end.
module bat_term #(
   parameter int BLK_MAX = `BAT_BLK_MAX
) (
   input wire logic clk,
   input wire logic rst,
   bat_link_if.term link,
   input wire logic [7:0] cmd_data,
   input wire logic cmd_valid,
   input wire logic cmd_last,
   output logic cmd_ready,
   output bat_pkg::bat_byte_t rsp_data,
   output logic rsp_valid,
   output logic rsp_last,
   input wire logic rsp_ready,
   output logic rsp_done,
   output bat_pkg::bat_byte_t status1,
   output bat_pkg::bat_byte_t status2,
   output logic pending,
   output bat_pkg::bat_byte_t pending_len,
   output logic env_ack,
   output logic env_nack
);
   import bat_pkg::*;
   bat_term_state_e state_reg;
   logic [7:0] blk_reg;
   logic [7:0] idx_reg;
   logic [7:0] ins_reg;
   logic [7:0] prev_reg;
   logic take;
   logic got;
   logic fin;

   initial begin
      if (BLK_MAX < 1 || BLK_MAX > 254) begin
         $error("bat_term: BLK_MAX must lie in 1..254");
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Command path through a one byte register stage.
   assign cmd_ready = (state_reg == BAT_T_SEND) &&
      (!link.t2c_valid || link.t2c_ready);
   assign take = cmd_valid && cmd_ready;

   // Bytes go out unaltered; a full block is chained to the next.
   always_ff @(posedge clk) begin
      if (rst) begin
         link.t2c_data <= 8'h00;
         link.t2c_valid <= 1'b0;
         link.t2c_last <= 1'b0;
         link.t2c_chain <= 1'b0;
      end else if (take) begin
         link.t2c_data <= cmd_data;
         link.t2c_valid <= 1'b1;
         link.t2c_last <= cmd_last || blk_reg == 8'(BLK_MAX - 1);
         link.t2c_chain <= !cmd_last;
      end else if (link.t2c_ready) begin
         link.t2c_valid <= 1'b0;
      end
   end

   // Block fill count, and the instruction byte of each command.
   always_ff @(posedge clk) begin
      if (rst) begin
         blk_reg <= 8'h00;
         idx_reg <= 8'h00;
         ins_reg <= 8'h00;
      end else if (take) begin
         blk_reg <= (cmd_last || blk_reg == 8'(BLK_MAX - 1)) ? 8'h00 :
            blk_reg + 8'h01;
         idx_reg <= cmd_last ? 8'h00 : idx_reg + 8'h01;
         if (idx_reg == `BAT_INS_POS) begin
            ins_reg <= cmd_data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Response path: every field byte, status included, goes upward.
   assign link.c2t_ready = !rsp_valid || rsp_ready;
   assign got = link.c2t_valid && link.c2t_ready;
   assign fin = got && link.c2t_last && !link.c2t_chain;

   // Chained fields are concatenated in arrival order.
   always_ff @(posedge clk) begin
      if (rst) begin
         rsp_data <= 8'h00;
         rsp_valid <= 1'b0;
         rsp_last <= 1'b0;
         prev_reg <= 8'h00;
      end else if (got) begin
         rsp_data <= link.c2t_data;
         rsp_valid <= 1'b1;
         rsp_last <= fin;
         prev_reg <= link.c2t_data;
      end else if (rsp_ready) begin
         rsp_valid <= 1'b0;
      end
   end

   // Status words and toolkit indications taken at unit end.
   always_ff @(posedge clk) begin
      if (rst) begin
         rsp_done <= 1'b0;
         status1 <= 8'h00;
         status2 <= 8'h00;
         pending <= 1'b0;
         pending_len <= 8'h00;
         env_ack <= 1'b0;
         env_nack <= 1'b0;
      end else begin
         rsp_done <= fin;
         env_ack <= 1'b0;
         env_nack <= 1'b0;
         if (fin) begin
            status1 <= prev_reg;
            status2 <= link.c2t_data;
            // Pending length is what the next FETCH must request.
            pending <= (prev_reg == `BAT_SW1_PENDING);
            pending_len <= (prev_reg == `BAT_SW1_PENDING) ?
               link.c2t_data : 8'h00;
            if (ins_reg == `BAT_INS_ENVELOPE) begin
               env_ack <= prev_reg == `BAT_SW1_OK &&
                  link.c2t_data == `BAT_SW2_OK;
               env_nack <= prev_reg == `BAT_SW1_WARN_A ||
                  prev_reg == `BAT_SW1_WARN_B;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // One command in flight until its whole response is back.
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= BAT_T_SEND;
      end else begin
         case (state_reg)
            BAT_T_SEND: begin
               if (take && cmd_last) begin
                  state_reg <= BAT_T_WAIT;
               end
            end
            BAT_T_WAIT: begin
               if (fin) begin
                  state_reg <= BAT_T_SEND;
               end
            end
            default: begin
               state_reg <= BAT_T_SEND;
            end
         endcase
      end
   end
endmodule

// *** test/bat_link_properties.sv ***
// Checker for the byte link between the card end and the terminal end.
`timescale 1ns/100ps
`include "bat_cfg.svh"
module bat_link_props #(
   parameter int BLK_MAX = `BAT_BLK_MAX
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] t2c_data,
   input wire logic t2c_valid,
   input wire logic t2c_last,
   input wire logic t2c_chain,
   input wire logic t2c_ready,
   input wire logic [7:0] c2t_data,
   input wire logic c2t_valid,
   input wire logic c2t_last,
   input wire logic c2t_chain,
   input wire logic c2t_ready
);
   logic wait_reg;
   logic [7:0] tcnt_reg;
   logic [7:0] ccnt_reg;
   logic t_take;
   logic c_take;

   ////////////////////////////////////////////////////////////////////
   // Byte transfers in each direction.
   assign t_take = t2c_valid && t2c_ready;
   assign c_take = c2t_valid && c2t_ready;

   // High from the close of a command unit to the close of its answer.
   always_ff @(posedge clk) begin
      if (rst) begin
         wait_reg <= 1'b0;
      end else if (t_take && t2c_last && !t2c_chain) begin
         wait_reg <= 1'b1;
      end else if (c_take && c2t_last && !c2t_chain) begin
         wait_reg <= 1'b0;
      end
   end

   // Byte position in the current block, so block size can be bounded.
   always_ff @(posedge clk) begin
      if (rst || (t_take && t2c_last)) begin
         tcnt_reg <= 8'h00;
      end else if (t_take) begin
         tcnt_reg <= tcnt_reg + 8'h01;
      end
   end

   // Same position count on the answer direction.
   always_ff @(posedge clk) begin
      if (rst || (c_take && c2t_last)) begin
         ccnt_reg <= 8'h00;
      end else if (c_take) begin
         ccnt_reg <= ccnt_reg + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Properties; one clock domain, so the defaults apply to all.
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   cmd_byte_hold_a: assert property (t2c_valid && !t2c_ready |=>
      t2c_valid && $stable(t2c_data) && $stable({t2c_last, t2c_chain}))
      else $error("command byte changed before it was taken");
   rsp_byte_hold_a: assert property (c2t_valid && !c2t_ready |=>
      c2t_valid && $stable(c2t_data) && $stable({c2t_last, c2t_chain}))
      else $error("response byte changed before it was taken");
   one_cmd_a: assert property (wait_reg |-> !t2c_valid)
      else $error("new command before response ended");
   rsp_owed_a: assert property (c2t_valid |-> wait_reg)
      else $error("response byte without a command");
   cmd_blk_size_a: assert property (t_take |->
      int'(tcnt_reg) < BLK_MAX) else $error("command block too long");
   rsp_blk_size_a: assert property (c_take |->
      int'(ccnt_reg) < BLK_MAX) else $error("response block too long");
   cmd_chain_full_a: assert property (
      (t_take && t2c_last && t2c_chain) |-> int'(tcnt_reg) == BLK_MAX - 1)
      else $error("short chained command block");
   rsp_chain_full_a: assert property (
      (c_take && c2t_last && c2t_chain) |-> int'(ccnt_reg) == BLK_MAX - 1)
      else $error("short chained response block");

   cover property (c_take && c2t_last && c2t_chain);
   cover property (t_take && t2c_last && t2c_chain);
   cover property (c2t_valid && !c2t_ready);
endmodule

// *** test/tb.sv ***
// Self-checking bench joining the card end and the terminal end.
`timescale 1ns/100ps
`include "bat_cfg.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
   mismatches++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
   import bat_pkg::*;
   localparam int BLK = 4;
   logic clk = 1'b0, rst = 1'b1, t_cv = 1'b0, t_cl = 1'b0, r_rdy = 1'b0;
   logic c_rdy = 1'b0, swv = 1'b0, av = 1'b0, busy = 1'b0;
   logic [7:0] t_cd = '0, sw1 = '0, sw2 = '0, rlen = '0, ad = '0, pl = '0;
   logic t_cr, r_v, r_l, r_done, pend, eack, enack, c_v, c_e, swr, ar;
   bat_byte_t r_d, st1, st2, plen, c_d, c_ins;
   int mismatches = 0, n_compared = 0, ndone = 0, nack = 0, nnack = 0;
   bat_byte_t ins_tab[6] = '{8'h01, 8'h12, 8'h14, 8'hC2, 8'hA4, 8'hB0};
   bat_byte_t sw_tab[7] = '{8'h90, 8'h61, 8'h62, 8'h63, 8'h6A, 8'h92, 8'h6F};

   // Clock at 200 MHz.
   always #2.5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////
   // Both ends face each other across one link.
   bat_link_if link_if();
   bat_card #(.BLK_MAX(BLK), .FIFO_DEPTH(`BAT_FIFO_DEPTH)) u_bat_card (
      .clk(clk), .rst(rst), .link(link_if.card), .cmd_data(c_d),
      .cmd_valid(c_v), .cmd_end(c_e), .cmd_ready(c_rdy), .cmd_ins(c_ins),
      .sw1(sw1), .sw2(sw2), .rsp_len(rlen), .sw_valid(swv),
      .sw_ready(swr), .rsp_data(ad), .rsp_valid(av), .rsp_ready(ar),
      .pending_len(pl), .toolkit_busy(busy));
   bat_term #(.BLK_MAX(BLK)) u_bat_term (
      .clk(clk), .rst(rst), .link(link_if.term), .cmd_data(t_cd),
      .cmd_valid(t_cv), .cmd_last(t_cl), .cmd_ready(t_cr), .rsp_data(r_d),
      .rsp_valid(r_v), .rsp_last(r_l), .rsp_ready(r_rdy),
      .rsp_done(r_done), .status1(st1), .status2(st2), .pending(pend),
      .pending_len(plen), .env_ack(eack), .env_nack(enack));
   bat_link_props #(.BLK_MAX(BLK)) u_props (
      .clk(clk), .rst(rst), .t2c_data(link_if.t2c_data),
      .t2c_valid(link_if.t2c_valid), .t2c_last(link_if.t2c_last),
      .t2c_chain(link_if.t2c_chain), .t2c_ready(link_if.t2c_ready),
      .c2t_data(link_if.c2t_data), .c2t_valid(link_if.c2t_valid),
      .c2t_last(link_if.c2t_last), .c2t_chain(link_if.c2t_chain),
      .c2t_ready(link_if.c2t_ready));

   // Random back-pressure on both user sides; the FIFO must ride it out.
   always @(posedge clk) begin
      #1;
      c_rdy = ($urandom_range(0, 3) != 0);
      r_rdy = ($urandom_range(0, 3) != 0);
   end

   // Count one-cycle pulses so none is missed while stalling.
   always @(posedge clk) begin
      if (!rst) begin
         ndone += int'(r_done === 1'b1);
         nack += int'(eack === 1'b1);
         nnack += int'(enack === 1'b1);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Final status the card should send, after its substitutions.
   function automatic logic [15:0] exp_sw(bat_byte_t ins, s1, s2, p,
                                          logic b);
      if (ins == `BAT_INS_ENVELOPE && b) return 16'h9300;
      if ({s1, s2} == 16'h9000 && p != 8'h00 && ins != `BAT_INS_FETCH)
         return {`BAT_SW1_PENDING, p};
      return {s1, s2};
   endfunction

   // Whether data may travel with the given final status.
   function automatic logic keep(bat_byte_t ins, logic b, bat_byte_t s1);
      if (ins == `BAT_INS_ENVELOPE && b) return 1'b0;
      return (s1 inside {8'h61, 8'h62, 8'h63}) || s1[7:4] == 4'h9;
   endfunction

   // One full exchange: command unit in, status and data out, answer back.
   task automatic xact(input bat_byte_t ins, input int nc, nr,
                       input bat_byte_t s1, s2, p, input logic b);
      bat_byte_t cq[$], dq[$], eq[$], got[$];
      logic [15:0] sw;
      int d0, a0, n0, ea, en;
      cq = {bat_byte_t'($urandom), ins, bat_byte_t'($urandom), 8'h00};
      for (int i = 0; i < nc; i++) cq.push_back(bat_byte_t'($urandom));
      for (int i = 0; i < nr; i++) dq.push_back(bat_byte_t'($urandom));
      sw = exp_sw(ins, s1, s2, p, b);
      if (keep(ins, b, sw[15:8])) eq = dq;
      eq.push_back(sw[15:8]);
      eq.push_back(sw[7:0]);
      d0 = ndone;
      a0 = nack;
      n0 = nnack;
      busy = b;
      pl = p;
      fork
         begin
            foreach (cq[i]) begin
               t_cd = cq[i];
               t_cl = (i == cq.size() - 1);
               t_cv = 1'b1;
               do @(posedge clk); while (t_cr !== 1'b1);
               #1;
            end
            t_cv = 1'b0;
            t_cl = 1'b0;
         end
         begin
            foreach (cq[i]) begin
               do @(posedge clk); while (!(c_v === 1'b1 && c_rdy));
               `CHK("cmd_data", cq[i], c_d)
               `CHK("cmd_end", i == cq.size() - 1, c_e)
            end
            #1;
            `CHK("cmd_ins", ins, c_ins)
            sw1 = s1;
            sw2 = s2;
            rlen = nr[7:0];
            swv = 1'b1;
            do @(posedge clk); while (swr !== 1'b1);
            #1;
            swv = 1'b0;
            foreach (dq[i]) begin
               ad = dq[i];
               av = 1'b1;
               do @(posedge clk); while (ar !== 1'b1);
               #1;
            end
            av = 1'b0;
         end
         begin
            do begin
               do @(posedge clk); while (!(r_v === 1'b1 && r_rdy));
               got.push_back(r_d);
            end while (r_l !== 1'b1);
         end
      join
      #1;
      // Acknowledgement pulses expected from the instruction and the final status.
      ea = a0 + int'(ins == `BAT_INS_ENVELOPE && sw == 16'h9000);
      en = n0 + int'(ins == `BAT_INS_ENVELOPE &&
         sw[15:8] inside {`BAT_SW1_WARN_A, `BAT_SW1_WARN_B});
      `CHK("rsp_count", eq.size(), got.size())
      foreach (eq[i]) begin
         if (i < got.size()) begin
            `CHK("rsp_byte", eq[i], got[i])
         end
      end
      `CHK("status1", sw[15:8], st1)
      `CHK("status2", sw[7:0], st2)
      `CHK("pending", sw[15:8] == `BAT_SW1_PENDING, pend)
      `CHK("pend_len", sw[15:8] == 8'h91 ? sw[7:0] : 8'h00, plen)
      `CHK("done", d0 + 1, ndone)
      `CHK("env_ack", ea, nack)
      `CHK("env_nack", en, nnack)
   endtask

   // Print the counts and the verdict, then end the run.
   task automatic report_and_stop;
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Watchdog; the tests need a few thousand cycles at most.
   initial begin
      repeat (40000) @(posedge clk);
      mismatches++;
      report_and_stop();
   end

   ////////////////////////////////////////////////////////////////////
   // Directed corners first, then random exchanges.
   initial begin
      void'($urandom(32'hf0f8_979d));
      repeat (4) @(posedge clk);
      #1 rst = 1'b0;
      xact(8'h01, 0, 0, 8'h90, 8'h00, 8'h00, 1'b0);
      xact(8'hB0, 0, 9, 8'h90, 8'h00, 8'h00, 1'b0);
      xact(8'hD6, 10, 0, 8'h90, 8'h00, 8'h00, 1'b0);
      xact(8'hA4, 2, 3, 8'h6A, 8'h82, 8'h00, 1'b0);
      xact(8'h88, 5, 3, 8'h61, 8'h10, 8'h00, 1'b0);
      xact(8'hA4, 3, 2, 8'h90, 8'h00, 8'h05, 1'b0);
      xact(`BAT_INS_FETCH, 0, 5, 8'h90, 8'h00, 8'h05, 1'b0);
      xact(`BAT_INS_TERM_RSP, 6, 0, 8'h90, 8'h00, 8'h00, 1'b0);
      xact(`BAT_INS_ENVELOPE, 4, 3, 8'h90, 8'h00, 8'h00, 1'b0);
      xact(`BAT_INS_ENVELOPE, 4, 2, 8'h63, 8'h01, 8'h00, 1'b0);
      xact(`BAT_INS_ENVELOPE, 3, 2, 8'h62, 8'h81, 8'h00, 1'b0);
      xact(`BAT_INS_ENVELOPE, 3, 2, 8'h90, 8'h00, 8'h00, 1'b1);
      repeat (20) begin
         xact(ins_tab[$urandom_range(0, 5)], $urandom_range(0, 9),
              $urandom_range(0, 9), sw_tab[$urandom_range(0, 6)],
              bat_byte_t'($urandom), bat_byte_t'($urandom_range(0, 3)),
              1'($urandom_range(0, 1)));
      end
      report_and_stop();
   end
endmodule
